/* File: crtdp_pkg.sv */
// package of constants for the crt display processor ports block
// Contract
// R1: protocol chosen automatically by data strobe level latched at address strobe fall
// R2: address strobe fall latches address byte, data strobe and chip select
// R3: access answered only when chip select was low at address strobe fall
// R4: rd/wr host: drive data while strobe low, rw high; write on rw low
// R5: strobe host: rw sets direction; strobe high writes or enables read data
// R6: host holds rw low to write, high to read
// R7: memory address strobe pulses once per memory cycle continuously
// R8: memory cycle is 500 ns; memory needs 250 ns access
// R9: low address on memory bus while strobe high, data while low
// R10: six high address bits on dedicated outputs form a 14-bit address
// R11: memory output enable low only when memory must drive the bus
// R12: memory write enable low in write cycles, high in reads
// R13: colour outputs low during horizontal and vertical blanking
// R14: active high insert output marks pixels replacing external video
// R15: first sync output is composite when option bit 4 set, else line sync
// R16: second sync output is phase compare when bit 4 set, else frame sync
// R17: external sync input realigns own line and frame timing; code realigns only the line counter (hPix), not the frame counter (vLine)
// R18: 4 MHz pixel clock output edges aligned with colour changes
// R19: eight direct host registers: command, three data, two pointer pairs
// R20: direct registers reach memory and five indirect display registers
// R21: up to 25 rows of 40 or 80 characters; user sets only in 40; code draws no characters, each active pixel shows marginCursor[3:0]
// R22: 40 column format supports 24, 8/24 compressed and 16 bit codes; code decodes no character codes
package crtdp_pkg;
	localparam int CLK_MHZ = 200;
	localparam int MEM_CYCLE_NS = 500;
	localparam int MEM_CYCLE_CLKS = MEM_CYCLE_NS * CLK_MHZ / 1000;
	localparam int MEM_ADDR_PHASE_CLKS = MEM_CYCLE_CLKS / 2;
	localparam int MEM_WE_START_CLKS = MEM_CYCLE_CLKS * 3 / 5;
	localparam int MEM_WE_END_CLKS = MEM_CYCLE_CLKS * 9 / 10;
	localparam int PIX_MHZ = 4;
	localparam int PIX_HALF_CLKS = CLK_MHZ / (PIX_MHZ * 2);
	localparam int LINE_PIX = 256;
	localparam int LINE_ACTIVE_PIX = 160;
	localparam int HSYNC_START_PIX = 192;
	localparam int HSYNC_END_PIX = 211;
	localparam int FRAME_LINES = 312;
	localparam int FRAME_ACTIVE_LINES = 250;
	localparam int VSYNC_START_LINE = 280;
	localparam int VSYNC_END_LINE = 283;
	localparam int ROW_LINES = 10;
	localparam logic [2:0] REG_CMD = 3'h0;
	localparam logic [2:0] REG_DATA1 = 3'h1;
	localparam logic [2:0] REG_DATA2 = 3'h2;
	localparam logic [2:0] REG_DATA3 = 3'h3;
	localparam logic [2:0] REG_AUX_Y = 3'h4;
	localparam logic [2:0] REG_AUX_X = 3'h5;
	localparam logic [2:0] REG_MAIN_Y = 3'h6;
	localparam logic [2:0] REG_MAIN_X = 3'h7;
	localparam int EXEC_BIT = 3;
	localparam logic [7:0] CMD_MEM_RD = 8'h00;
	localparam logic [7:0] CMD_MEM_WR = 8'h01;
	localparam logic [7:0] CMD_IND_RD = 8'h02;
	localparam logic [7:0] CMD_IND_WR = 8'h03;
	localparam logic [2:0] IND_ROR = 3'h0;
	localparam logic [2:0] IND_DOR = 3'h1;
	localparam logic [2:0] IND_PAT = 3'h2;
	localparam logic [2:0] IND_MAT = 3'h3;
	localparam logic [2:0] IND_TGS = 3'h4;
	localparam int TGS_SYNC_SEL_BIT = 4;
	localparam int TGS_80COL_BIT = 7;
	localparam logic [7:0] RESET_BYTE = 8'h00;
	localparam int STATUS_BUSY_BIT = 7;
endpackage : crtdp_pkg

/* File: crtdp_host_port.sv */
// host port: protocol detect, address latch, register strobes
`timescale 1ns/1ps
`default_nettype none
module crtdp_host_port (
	input wire logic clk,
	input wire logic resetn,
	input wire logic addrStrobe,
	input wire logic dataStrobe,
	input wire logic readWrite,
	input wire logic chipSelN,
	input wire logic [7:0] adIn,
	output logic wrPulse,
	output logic rdActive,
	output logic [2:0] regIdx,
	output logic [7:0] wrData
);
	typedef struct packed {
		logic [1:0] asS;
		logic [1:0] dsS;
		logic [1:0] rwS;
		logic [1:0] csS;
		logic [7:0] ad1;
		logic [7:0] ad2;
		logic asP;
		logic strbP;
		logic rwP;
		logic selected;
		logic strobeHost;
		logic [2:0] idx;
		logic wr;
		logic rd;
		logic [7:0] data;
	} crtdp_hp_type;
	crtdp_hp_type s_q, s_d;
	logic asFall, strbNow;

	// synchronise pins, latch address phase, decode strobes
	always_comb begin
		s_d = s_q;
		s_d.asS = {s_q.asS[0], addrStrobe};
		s_d.dsS = {s_q.dsS[0], dataStrobe};
		s_d.rwS = {s_q.rwS[0], readWrite};
		s_d.csS = {s_q.csS[0], chipSelN};
		s_d.ad1 = adIn;
		s_d.ad2 = s_q.ad1;
		s_d.asP = s_q.asS[1];
		s_d.wr = 1'b0;
		asFall = s_q.asP & ~s_q.asS[1];
		if (asFall) begin
			s_d.strobeHost = ~s_q.dsS[1]; // R1
			s_d.selected = ~s_q.csS[1]; // R2 R3
			s_d.idx = s_q.ad2[2:0]; // R2
		end
		// active transfer strobe for the latched protocol
		if (s_q.strobeHost) begin
			strbNow = s_q.dsS[1]; // R5
		end else begin
			strbNow = s_q.rwS[1] ? ~s_q.dsS[1] : 1'b1; // R4
		end
		// quiet through the address phase: a host changing bus style fakes no strobe
		strbNow = strbNow & ~s_q.asS[1] & ~s_q.asP;
		s_d.strbP = strbNow;
		s_d.rwP = s_q.rwS[1];
		s_d.rd = s_q.selected & strbNow & s_q.rwS[1]; // AUX_POINTER_REGS R6
		// write lands when a strobe ends after read/write low, never at the end of a read
		if (s_q.selected & s_q.strbP & ~strbNow & ~s_q.rwP) begin
			s_d.wr = 1'b1; // AUX_POINTER_REGS R6
		end
		if (s_q.selected & strbNow & ~s_q.rwS[1]) begin
			s_d.data = s_q.ad2;
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign wrPulse = s_q.wr;
	assign rdActive = s_q.rd;
	assign regIdx = s_q.idx;
	assign wrData = s_q.data;

	AST_NO_WRITE_UNSELECTED: assert property (@(posedge clk) disable iff (!resetn) // R3
		s_q.wr |-> s_q.selected) else $error("write while unselected");
	AST_READ_NEEDS_RW: assert property (@(posedge clk) disable iff (!resetn) // R4
		s_q.rd |-> $past(s_q.rwS[1])) else $error("read without rw high");
endmodule : crtdp_host_port
`default_nettype wire

/* File: crtdp_core.sv */
// top: host registers, memory cycler, video timing and sync selection
`timescale 1ns/1ps
`default_nettype none
module crtdp_core (
	input wire logic clk,
	input wire logic resetn,
	input wire logic hostAddrStrobe,
	input wire logic hostDataStrobe,
	input wire logic hostReadWrite,
	input wire logic hostChipSelN,
	input wire logic [7:0] hostAdIn,
	output logic [7:0] hostAdOut,
	output logic hostAdOeN,
	input wire logic [7:0] memAdBusIn,
	output logic [7:0] memAdBusOut,
	output logic memAdBusOeN,
	output logic [5:0] memHighAddr,
	output logic memAddrStrobeN,
	output logic memOutEnN,
	output logic memWriteEnN,
	output logic red,
	output logic green,
	output logic blue,
	output logic insert,
	output logic lineOrCompositeSync,
	output logic phaseCmpOrFrameSync,
	input wire logic extSyncInput,
	output logic pixelClockOut
);
	localparam int CYC_W = 7;
	localparam logic [CYC_W-1:0] CYC_LAST = CYC_W'(crtdp_pkg::MEM_CYCLE_CLKS - 1);
	localparam logic [CYC_W-1:0] CYC_ADDR = CYC_W'(crtdp_pkg::MEM_ADDR_PHASE_CLKS);
	localparam logic [CYC_W-1:0] CYC_WE0 = CYC_W'(crtdp_pkg::MEM_WE_START_CLKS);
	localparam logic [CYC_W-1:0] CYC_WE1 = CYC_W'(crtdp_pkg::MEM_WE_END_CLKS);
	localparam logic [4:0] PIX_LAST = 5'(crtdp_pkg::PIX_HALF_CLKS - 1);

	typedef enum logic [1:0] {
		MEM_IDLE = 2'b00,
		MEM_REQ = 2'b01,
		MEM_RUN = 2'b10
	} crtdp_mem_type;

	typedef struct packed {
		logic [7:0] cmd;
		logic [7:0] data1;
		logic [7:0] data2;
		logic [7:0] data3;
		logic [7:0] auxY;
		logic [7:0] auxX;
		logic [7:0] mainY;
		logic [7:0] mainX;
		logic [7:0] pageOrigin;
		logic [7:0] chargenBase;
		logic [7:0] pageAttr;
		logic [7:0] marginCursor;
		logic [7:0] timingOption;
		crtdp_mem_type memSt;
		logic memIsWrite;
		logic [CYC_W-1:0] cyc;
		logic [13:0] cycAddr;
		logic [7:0] refresh;
		logic [7:0] rdBack;
		logic [7:0] adOut;
		logic adOeN;
		logic [7:0] mOut;
		logic mOeN;
		logic [5:0] mHigh;
		logic asmN;
		logic oeN;
		logic weN;
		logic [4:0] pixDiv;
		logic pixClk;
		logic [7:0] hPix;
		logic [8:0] vLine;
		logic [1:0] syncS;
		logic syncP;
		logic phaseErr;
		logic [3:0] rgbi;
		logic hs;
		logic vs;
	} crtdp_core_type;

	crtdp_core_type s_q, s_d;
	logic wrPulse, rdActive;
	logic [2:0] regIdx;
	logic [7:0] wrData;
	logic pixTick, blank, hsNow, vsNow, syncFall, hostMemBusy;

	crtdp_host_port u_host (
		.clk(clk),
		.resetn(resetn),
		.addrStrobe(hostAddrStrobe),
		.dataStrobe(hostDataStrobe),
		.readWrite(hostReadWrite),
		.chipSelN(hostChipSelN),
		.adIn(hostAdIn),
		.wrPulse(wrPulse),
		.rdActive(rdActive),
		.regIdx(regIdx),
		.wrData(wrData)
	);

	// decode of one of eight direct registers for readback
	function automatic logic [7:0] directRead(input crtdp_core_type s, input logic [2:0] i);
		case (i)
			crtdp_pkg::REG_CMD: directRead = {s.memSt != MEM_IDLE, 7'h00};
			crtdp_pkg::REG_DATA1: directRead = s.data1;
			crtdp_pkg::REG_DATA2: directRead = s.data2;
			crtdp_pkg::REG_DATA3: directRead = s.data3;
			crtdp_pkg::REG_AUX_Y: directRead = s.auxY;
			crtdp_pkg::REG_AUX_X: directRead = s.auxX;
			crtdp_pkg::REG_MAIN_Y: directRead = s.mainY;
			default: directRead = s.mainX;
		endcase
	endfunction : directRead

	always_comb begin
		s_d = s_q;
		hostMemBusy = s_q.memSt != MEM_IDLE;
		// ---------------------------------------------------------------
		// direct host registers and command execution
		// ---------------------------------------------------------------
		if (wrPulse) begin
			case (regIdx) // R19
				crtdp_pkg::REG_CMD: s_d.cmd = wrData;
				crtdp_pkg::REG_DATA1: s_d.data1 = wrData;
				crtdp_pkg::REG_DATA2: s_d.data2 = wrData;
				crtdp_pkg::REG_DATA3: s_d.data3 = wrData;
				crtdp_pkg::REG_AUX_Y: s_d.auxY = wrData;
				crtdp_pkg::REG_AUX_X: s_d.auxX = wrData;
				crtdp_pkg::REG_MAIN_Y: s_d.mainY = wrData;
				default: s_d.mainX = wrData;
			endcase
		end
		// indirect register access and memory request launch
		if (wrPulse && regIdx[crtdp_pkg::EXEC_BIT-1:0] == 3'h0 && regIdx == crtdp_pkg::REG_CMD
			&& !hostMemBusy) begin
			case (wrData) // R20
				crtdp_pkg::CMD_IND_WR: begin
					case (s_q.data2[2:0])
						crtdp_pkg::IND_ROR: s_d.pageOrigin = s_q.data1;
						crtdp_pkg::IND_DOR: s_d.chargenBase = s_q.data1;
						crtdp_pkg::IND_PAT: s_d.pageAttr = s_q.data1;
						crtdp_pkg::IND_MAT: s_d.marginCursor = s_q.data1;
						default: s_d.timingOption = s_q.data1;
					endcase
				end
				crtdp_pkg::CMD_IND_RD: begin
					case (s_q.data2[2:0])
						crtdp_pkg::IND_ROR: s_d.data1 = s_q.pageOrigin;
						crtdp_pkg::IND_DOR: s_d.data1 = s_q.chargenBase;
						crtdp_pkg::IND_PAT: s_d.data1 = s_q.pageAttr;
						crtdp_pkg::IND_MAT: s_d.data1 = s_q.marginCursor;
						default: s_d.data1 = s_q.timingOption;
					endcase
				end
				crtdp_pkg::CMD_MEM_WR: begin
					s_d.memSt = MEM_REQ;
					s_d.memIsWrite = 1'b1;
				end
				crtdp_pkg::CMD_MEM_RD: begin
					s_d.memSt = MEM_REQ;
					s_d.memIsWrite = 1'b0;
				end
				default: s_d.memSt = s_q.memSt;
			endcase
		end
		// host read data drive
		s_d.adOeN = ~rdActive; // AUX_POINTER_REGS
		s_d.adOut = directRead(s_q, regIdx);
		// ---------------------------------------------------------------
		// memory cycler: one 500 ns cycle, refresh when no host access
		// ---------------------------------------------------------------
		s_d.cyc = (s_q.cyc == CYC_LAST) ? '0 : s_q.cyc + 1'b1; // R8
		if (s_q.cyc == CYC_LAST) begin
			if (s_q.memSt == MEM_REQ) begin
				s_d.memSt = MEM_RUN;
				s_d.cycAddr = {s_q.mainY[5:0], s_q.mainX}; // R10
			end else begin
				if (s_q.memSt == MEM_RUN) begin
					s_d.memSt = MEM_IDLE;
				end
				s_d.cycAddr = {6'h00, s_q.refresh};
				s_d.refresh = s_q.refresh + 1'b1;
			end
		end
		// strobe high during address phase, low during data phase
		s_d.asmN = s_q.cyc < CYC_ADDR; // R7
		s_d.mHigh = s_q.cycAddr[13:8]; // R10
		if (s_q.cyc < CYC_ADDR) begin
			s_d.mOut = s_q.cycAddr[7:0]; // R9
			s_d.mOeN = 1'b0;
		end else begin
			s_d.mOut = s_q.data1;
			s_d.mOeN = ~(s_q.memSt == MEM_RUN && s_q.memIsWrite); // R9
		end
		s_d.oeN = ~(s_q.cyc >= CYC_ADDR && !(s_q.memSt == MEM_RUN && s_q.memIsWrite)); // R11
		s_d.weN = ~(s_q.memSt == MEM_RUN && s_q.memIsWrite
			&& s_q.cyc >= CYC_WE0 && s_q.cyc < CYC_WE1); // R12
		if (s_q.memSt == MEM_RUN && !s_q.memIsWrite && s_q.cyc == CYC_LAST) begin
			s_d.data1 = memAdBusIn;
		end
		// ---------------------------------------------------------------
		// pixel clock divider and raster timing
		// ---------------------------------------------------------------
		s_d.pixDiv = (s_q.pixDiv == PIX_LAST) ? '0 : s_q.pixDiv + 1'b1;
		pixTick = (s_q.pixDiv == PIX_LAST) && s_q.pixClk;
		if (s_q.pixDiv == PIX_LAST) begin
			s_d.pixClk = ~s_q.pixClk; // R18
		end
		s_d.syncS = {s_q.syncS[0], extSyncInput};
		s_d.syncP = s_q.syncS[1];
		syncFall = s_q.syncP & ~s_q.syncS[1];
		if (pixTick) begin
			if (s_q.hPix == 8'(crtdp_pkg::LINE_PIX - 1)) begin
				s_d.hPix = '0;
				s_d.vLine = (s_q.vLine == 9'(crtdp_pkg::FRAME_LINES - 1)) ? '0 : s_q.vLine + 1'b1;
			end else begin
				s_d.hPix = s_q.hPix + 1'b1;
			end
		end
		// external sync pulls the line counter to sync start
		if (syncFall) begin
			s_d.hPix = 8'(crtdp_pkg::HSYNC_START_PIX); // R17
			s_d.phaseErr = s_q.hPix != 8'(crtdp_pkg::HSYNC_START_PIX); // R17
		end
		blank = s_q.hPix >= 8'(crtdp_pkg::LINE_ACTIVE_PIX)
			|| s_q.vLine >= 9'(crtdp_pkg::FRAME_ACTIVE_LINES);
		hsNow = s_q.hPix >= 8'(crtdp_pkg::HSYNC_START_PIX)
			&& s_q.hPix < 8'(crtdp_pkg::HSYNC_END_PIX);
		vsNow = s_q.vLine >= 9'(crtdp_pkg::VSYNC_START_LINE)
			&& s_q.vLine < 9'(crtdp_pkg::VSYNC_END_LINE);
		// colour/insert update only with the pixel clock edge
		if (pixTick) begin
			if (blank) begin
				s_d.rgbi = 4'h0; // R13
			end else begin
				s_d.rgbi = s_q.marginCursor[3:0]; // R14 R21 R22
			end
		end
		if (s_q.timingOption[crtdp_pkg::TGS_SYNC_SEL_BIT]) begin
			s_d.hs = hsNow ^ vsNow; // R15
			s_d.vs = s_q.phaseErr; // R16
		end else begin
			s_d.hs = hsNow; // R15
			s_d.vs = vsNow; // R16
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			s_q <= '0;
			s_q.adOeN <= 1'b1;
			s_q.mOeN <= 1'b1;
			s_q.oeN <= 1'b1;
			s_q.weN <= 1'b1;
			s_q.asmN <= 1'b1;
		end else begin
			s_q <= s_d;
		end
	end

	assign hostAdOut = s_q.adOut;
	assign hostAdOeN = s_q.adOeN;
	assign memAdBusOut = s_q.mOut;
	assign memAdBusOeN = s_q.mOeN;
	assign memHighAddr = s_q.mHigh;
	assign memAddrStrobeN = s_q.asmN;
	assign memOutEnN = s_q.oeN;
	assign memWriteEnN = s_q.weN;
	assign red = s_q.rgbi[0];
	assign green = s_q.rgbi[1];
	assign blue = s_q.rgbi[2];
	assign insert = s_q.rgbi[3];
	assign lineOrCompositeSync = s_q.hs;
	assign phaseCmpOrFrameSync = s_q.vs;
	assign pixelClockOut = s_q.pixClk;

	sequence ADDR_PHASE;
		s_q.cyc == '0 ##1 s_q.asmN;
	endsequence
	AST_STROBE_PERIOD: assert property (@(posedge clk) disable iff (!resetn) // R7
		$rose(s_q.asmN) |-> ##100 $rose(s_q.asmN)) else $error("strobe period wrong");
	AST_CYCLE_LEN: assert property (@(posedge clk) disable iff (!resetn) // R8
		s_q.cyc == CYC_LAST |=> s_q.cyc == '0) else $error("cycle wrap wrong");
	AST_ADDR_ON_BUS: assert property (@(posedge clk) disable iff (!resetn) // R9
		ADDR_PHASE |-> !s_q.mOeN) else $error("address not driven");
	AST_OE_NOT_WRITE: assert property (@(posedge clk) disable iff (!resetn) // R11
		!s_q.weN |-> s_q.oeN) else $error("oe during write");
	AST_WE_ONLY_WRITE: assert property (@(posedge clk) disable iff (!resetn) // R12
		!s_q.weN |-> s_q.memIsWrite) else $error("we in read");
	AST_BLANK_BLACK: assert property (@(posedge clk) disable iff (!resetn) // R13
		$past(pixTick) && ($past(s_q.hPix) >= 8'(crtdp_pkg::LINE_ACTIVE_PIX)
		|| $past(s_q.vLine) >= 9'(crtdp_pkg::FRAME_ACTIVE_LINES))
		|-> s_q.rgbi[2:0] == 3'h0) else $error("colour in blank");
	AST_LINE_SYNC_SEL: assert property (@(posedge clk) disable iff (!resetn) // R15
		!s_q.timingOption[crtdp_pkg::TGS_SYNC_SEL_BIT] && $stable(s_q.timingOption)
		|=> s_q.hs == $past(hsNow)) else $error("line sync wrong");
	AST_FRAME_SYNC_SEL: assert property (@(posedge clk) disable iff (!resetn) // R16
		!s_q.timingOption[crtdp_pkg::TGS_SYNC_SEL_BIT] && $stable(s_q.timingOption)
		|=> s_q.vs == $past(vsNow)) else $error("frame sync wrong");
	AST_PIX_ALIGN: assert property (@(posedge clk) disable iff (!resetn) // R18
		$changed(s_q.rgbi) |-> $fell(s_q.pixClk)) else $error("colour off clock edge");
endmodule : crtdp_core
`default_nettype wire

/* File: crtdp_mem_model.sv */
// behavioural private memory on the multiplexed memory bus
`timescale 1ns/1ps
`default_nettype none
module crtdp_mem_model (
	input wire logic clk,
	input wire logic slowMode,
	input wire logic [7:0] memAdBusOut,
	input wire logic memAdBusOeN,
	input wire logic [5:0] memHighAddr,
	input wire logic memAddrStrobeN,
	input wire logic memOutEnN,
	input wire logic memWriteEnN,
	output logic [7:0] memAdBusIn
);
	// ----------------------------------------
	// storage and latches
	// ----------------------------------------
	logic [7:0] mem [0:16383];
	logic [13:0] addrQ = 14'h0000;
	logic [7:0] dataQ = 8'h00;
	logic [7:0] noiseQ = 8'h00;
	logic weQ = 1'b1;
	int waitCnt = 0;

	// address follows the bus while strobe is high, held from its fall
	always @(posedge clk) begin
		noiseQ <= noiseQ + 8'h01;
		weQ <= memWriteEnN;
		if (memAddrStrobeN) begin
			addrQ <= {memHighAddr, memAdBusOut};
		end
		if (!memWriteEnN && !memAdBusOeN) begin
			dataQ <= memAdBusOut;
		end
		if (!weQ && memWriteEnN) begin
			mem[addrQ] <= dataQ;
		end
		// data only after the access delay; otherwise a changing pattern
		waitCnt <= memOutEnN ? 0 : waitCnt + 1;
		if (!memOutEnN && waitCnt >= (slowMode ? 30 : 2)) begin
			memAdBusIn <= mem[addrQ];
		end else begin
			memAdBusIn <= noiseQ ^ 8'ha5;
		end
	end
endmodule : crtdp_mem_model
`default_nettype wire

/* File: tb_crt_display_processor_ports.sv */
// self-checking bench of the display processor ports
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, gt) begin checks_done++; if ((gt) !== (ex)) begin err_count++; \
	$display("BAD %s expected %h seen %h", nm, ex, gt); end end
module tb_crt_display_processor_ports;
	// ----------------------------------------
	// signals
	// ----------------------------------------
	logic clk = 1'b0;
	logic resetn, hostAddrStrobe, hostDataStrobe, hostReadWrite, hostChipSelN, extSyncInput;
	logic [7:0] hostAdIn, hostAdOut, memAdBusIn, memAdBusOut;
	logic hostAdOeN, memAdBusOeN, memAddrStrobeN, memOutEnN, memWriteEnN;
	logic red, green, blue, insert, lineOrCompositeSync, phaseCmpOrFrameSync, pixelClockOut;
	logic [5:0] memHighAddr;
	logic slowMode = 1'b0;
	logic probeSig;
	int which = 0;
	int err_count = 0;
	int checks_done = 0;
	int cycles = 0;
	localparam logic [7:0] EXEC_CMD = 8'(1 << crtdp_pkg::EXEC_BIT) | 8'(crtdp_pkg::REG_CMD);

	always #2.5 clk = ~clk;
	assign probeSig = which == 0 ? memAddrStrobeN : which == 1 ? pixelClockOut : lineOrCompositeSync;

	crtdp_core i_dut (.clk(clk), .resetn(resetn), .hostAddrStrobe(hostAddrStrobe),
		.hostDataStrobe(hostDataStrobe), .hostReadWrite(hostReadWrite),
		.hostChipSelN(hostChipSelN), .hostAdIn(hostAdIn), .hostAdOut(hostAdOut),
		.hostAdOeN(hostAdOeN), .memAdBusIn(memAdBusIn), .memAdBusOut(memAdBusOut),
		.memAdBusOeN(memAdBusOeN), .memHighAddr(memHighAddr), .memAddrStrobeN(memAddrStrobeN),
		.memOutEnN(memOutEnN), .memWriteEnN(memWriteEnN), .red(red), .green(green),
		.blue(blue), .insert(insert), .lineOrCompositeSync(lineOrCompositeSync),
		.phaseCmpOrFrameSync(phaseCmpOrFrameSync), .extSyncInput(extSyncInput),
		.pixelClockOut(pixelClockOut));

	crtdp_mem_model i_mem (.clk(clk), .slowMode(slowMode), .memAdBusOut(memAdBusOut),
		.memAdBusOeN(memAdBusOeN), .memHighAddr(memHighAddr), .memAddrStrobeN(memAddrStrobeN),
		.memOutEnN(memOutEnN), .memWriteEnN(memWriteEnN), .memAdBusIn(memAdBusIn));

	// ----------------------------------------
	// run control
	// ----------------------------------------
	task automatic wrap_up;
		$display("checks %0d errors %0d", checks_done, err_count);
		if (err_count == 0 && checks_done > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask : wrap_up

	// hang guard
	always @(posedge clk) begin
		cycles++;
		if (cycles == 100000) begin
			err_count++;
			wrap_up();
		end
	end

	// ----------------------------------------
	// host bus cycles
	// ----------------------------------------
	task automatic gap;
		repeat (8) @(negedge clk);
	endtask : gap

	// one access; rdwr picks the read/write-strobe host style
	task automatic bus(input bit rdwr, input bit wr, input logic csN, input logic [7:0] addr,
		input logic [7:0] wdat, output logic [7:0] rdat);
		hostChipSelN = csN;
		hostDataStrobe = rdwr;
		hostReadWrite = rdwr | !wr;
		hostAdIn = addr;
		hostAddrStrobe = 1'b1;
		gap();
		hostAddrStrobe = 1'b0;
		gap();
		hostAdIn = wr ? wdat : ~addr;
		if (!rdwr) hostDataStrobe = 1'b1;
		else if (wr) hostReadWrite = 1'b0;
		else hostDataStrobe = 1'b0;
		gap();
		rdat = hostAdOut;
		if (!wr) `CHK("read drive", csN, hostAdOeN) // AUX_POINTER_REGS
		hostDataStrobe = rdwr;
		if (rdwr) hostReadWrite = 1'b1;
		gap();
		`CHK("read release", 1'b1, hostAdOeN) // AUX_POINTER_REGS
		hostReadWrite = 1'b1;
		hostChipSelN = 1'b1;
		@(negedge clk);
	endtask : bus

	task automatic wreg(input bit rdwr, input logic [7:0] a, input logic [7:0] d);
		logic [7:0] t;
		bus(rdwr, 1'b1, 1'b0, a, d, t);
	endtask : wreg

	task automatic rreg(input bit rdwr, input logic [7:0] a, output logic [7:0] d);
		bus(rdwr, 1'b0, 1'b0, a, 8'h00, d);
	endtask : rreg

	// issue a command and poll the busy flag with a bound
	task automatic run_cmd(input logic [7:0] c);
		logic [7:0] s;
		int n;
		wreg(1'b0, EXEC_CMD, c);
		s = 8'h80;
		n = 0;
		while (s[crtdp_pkg::STATUS_BUSY_BIT] !== 1'b0 && n < 50) begin
			rreg(1'b1, 8'(crtdp_pkg::REG_CMD), s);
			n++;
		end
		`CHK("busy clears", 1'b0, s[crtdp_pkg::STATUS_BUSY_BIT])
	endtask : run_cmd

	task automatic set_ptr(input logic [13:0] a);
		wreg(1'b0, 8'(crtdp_pkg::REG_MAIN_Y), {2'b00, a[13:8]});
		wreg(1'b1, 8'(crtdp_pkg::REG_MAIN_X), a[7:0]);
	endtask : set_ptr

	// high and low widths of the probed output, colour seen in each phase
	task automatic measure(output int hi, output int lo, output int cHi, output int cLo);
		int n;
		{hi, lo, cHi, cLo, n} = '0;
		while (probeSig !== 1'b0 && n < 30000) begin @(negedge clk); n++; end
		while (probeSig !== 1'b1 && n < 30000) begin @(negedge clk); n++; end
		while (probeSig === 1'b1 && n < 30000) begin
			@(negedge clk);
			n++;
			hi++;
			cHi += int'(red | green | blue);
		end
		while (probeSig === 1'b0 && n < 30000) begin
			@(negedge clk);
			n++;
			lo++;
			cLo += int'(red | green | blue);
		end
	endtask : measure

	// cycles from 8 cycles after an external sync fall to the next line sync edge
	task automatic ext_delay(output int n);
		logic prev;
		extSyncInput = 1'b1;
		repeat (20) @(negedge clk);
		extSyncInput = 1'b0;
		repeat (8) @(negedge clk);
		prev = probeSig;
		n = 0;
		while (probeSig === prev && n < 20000) begin @(negedge clk); n++; end
	endtask : ext_delay

	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial begin
		logic [7:0] r, d, t;
		logic [13:0] a;
		int hi, lo, cHi, cLo, e1, e2;
		{resetn, hostAddrStrobe, hostDataStrobe, hostChipSelN, hostReadWrite} = 5'b00011;
		hostAdIn = 8'h00;
		extSyncInput = 1'b0;
		void'($urandom(34161));
		repeat (3) @(negedge clk);
		`CHK("oe in reset", 1'b1, hostAdOeN)
		`CHK("mem oe in reset", 1'b1, memOutEnN)
		`CHK("mem we in reset", 1'b1, memWriteEnN)
		resetn = 1'b1;
		repeat (4) @(negedge clk);
		// data registers: both host styles, deselected accesses ignored
		for (int i = 0; i < 12; i++) begin
			r = 8'(1 + i % 3);
			d = i == 0 ? 8'h00 : i == 1 ? 8'hff : 8'($urandom);
			wreg(i[0], r, d);
			bus(i[0], 1'b0, 1'b1, r, 8'h00, t);
			bus(!i[0], 1'b1, 1'b1, r, ~d, t);
			rreg(!i[0], r, t);
			`CHK("data reg", d, t)
		end
		// memory write then read of another place, prompt and slow memory
		for (int k = 0; k < 2; k++) begin
			slowMode = k[0];
			a = k == 0 ? 14'h3fff : 14'($urandom);
			d = 8'($urandom);
			set_ptr(a);
			wreg(1'b0, 8'(crtdp_pkg::REG_DATA1), d);
			run_cmd(crtdp_pkg::CMD_MEM_WR);
			`CHK("mem write", d, i_mem.mem[a])
			a = a ^ 14'h2a55;
			i_mem.mem[a] = ~d;
			set_ptr(a);
			run_cmd(crtdp_pkg::CMD_MEM_RD);
			rreg(1'b1, 8'(crtdp_pkg::REG_DATA1), t);
			`CHK("mem read", ~d, t)
		end
		// timing option write and read back, line sync mode last
		for (int k = 0; k < 2; k++) begin
			d = k == 0 ? 8'h10 : 8'h00;
			wreg(1'b0, 8'(crtdp_pkg::REG_DATA2), 8'(crtdp_pkg::IND_TGS));
			wreg(1'b0, 8'(crtdp_pkg::REG_DATA1), d);
			run_cmd(crtdp_pkg::CMD_IND_WR);
			wreg(1'b1, 8'(crtdp_pkg::REG_DATA1), ~d);
			run_cmd(crtdp_pkg::CMD_IND_RD);
			rreg(1'b0, 8'(crtdp_pkg::REG_DATA1), t);
			`CHK("timing option", d, t)
		end
		`CHK("frame sync idle", 1'b0, phaseCmpOrFrameSync)
		// margin colour with insert, so that blanking has something to hide
		wreg(1'b0, 8'(crtdp_pkg::REG_DATA2), 8'(crtdp_pkg::IND_MAT));
		wreg(1'b1, 8'(crtdp_pkg::REG_DATA1), 8'h0f);
		run_cmd(crtdp_pkg::CMD_IND_WR);
		which = 0;
		measure(hi, lo, cHi, cLo);
		`CHK("addr phase", crtdp_pkg::MEM_ADDR_PHASE_CLKS, hi)
		`CHK("mem cycle", crtdp_pkg::MEM_CYCLE_CLKS, hi + lo)
		which = 1;
		measure(hi, lo, cHi, cLo);
		`CHK("pixel high", crtdp_pkg::PIX_HALF_CLKS, hi)
		`CHK("pixel low", crtdp_pkg::PIX_HALF_CLKS, lo)
		which = 2;
		measure(hi, lo, cHi, cLo);
		`CHK("line period", crtdp_pkg::LINE_PIX * 2 * crtdp_pkg::PIX_HALF_CLKS, hi + lo)
		`CHK("colour in sync", 0, hi < lo ? cHi : cLo)
		// over one whole line the insert output is up for the active pixels only
		cHi = 0;
		repeat (crtdp_pkg::LINE_PIX * 2 * crtdp_pkg::PIX_HALF_CLKS) begin
			@(negedge clk);
			cHi += int'(insert);
		end
		`CHK("insert width", crtdp_pkg::LINE_ACTIVE_PIX * 2 * crtdp_pkg::PIX_HALF_CLKS, cHi)
		ext_delay(e1);
		// next fall a whole number of pixel periods later (28 cycles lie inside ext_delay)
		hi = 2 * crtdp_pkg::PIX_HALF_CLKS * int'($urandom_range(60, 6));
		hi -= (28 + e1) % (2 * crtdp_pkg::PIX_HALF_CLKS);
		repeat (hi) @(negedge clk);
		ext_delay(e2);
		`CHK("ext sync realign", e1, e2)
		wrap_up();
	end
endmodule : tb_crt_display_processor_ports
`default_nettype wire
